// ==== src/ppfs_params.svh ====
`ifndef PPFS_PARAMS_SVH
`define PPFS_PARAMS_SVH
// bus widths
`define PPFS_AW            8
`define PPFS_DW            8
// port widths
`define PPFS_P1_W          8
`define PPFS_P2_W          8
`define PPFS_P3_W          4
`define PPFS_P6_W          2
`define PPFS_P7_W          8
`define PPFS_P12_W         5
`define PPFS_INTP_N        6
`define PPFS_IRQ_W         7
// register offsets
`define PPFS_P1_DATA       8'h00
`define PPFS_P1_DIR        8'h01
`define PPFS_P1_PU         8'h02
`define PPFS_P1_MODE       8'h03
`define PPFS_P2_DATA       8'h04
`define PPFS_P2_DIR        8'h05
`define PPFS_P2_ANALOG     8'h06
`define PPFS_P3_DATA       8'h08
`define PPFS_P3_DIR        8'h09
`define PPFS_P3_PU         8'h0A
`define PPFS_P3_MODE       8'h0B
`define PPFS_P6_DATA       8'h0C
`define PPFS_P6_DIR        8'h0D
`define PPFS_P6_MODE       8'h0E
`define PPFS_P7_DATA       8'h10
`define PPFS_P7_DIR        8'h11
`define PPFS_P7_PU         8'h12
`define PPFS_P7_MODE       8'h13
`define PPFS_P12_DATA      8'h14
`define PPFS_P12_DIR       8'h15
`define PPFS_P12_PU        8'h16
`define PPFS_P12_MODE      8'h17
`define PPFS_EDGE_RISE     8'h18
`define PPFS_EDGE_FALL     8'h19
`define PPFS_IRQ_STATUS    8'h1A
`define PPFS_IRQ_MASK      8'h1B
`define PPFS_SERIAL_SEL    8'h1C
// reset values
`define PPFS_P2_ANALOG_RST 8'hFF
// field positions
`define PPFS_KEY_BIT       6
`define PPFS_P1_SCK_BIT    0
`define PPFS_P1_SI_BIT     1
`define PPFS_P1_SO_BIT     2
`define PPFS_P1_TXB_BIT    3
`define PPFS_P1_RXB_BIT    4
`define PPFS_P1_TOHA_BIT   5
`define PPFS_P1_TOHB_BIT   6
`define PPFS_P1_T8A_BIT    7
`define PPFS_P3_T8B_BIT    3
`define PPFS_P12_INTP_BIT  0
`define PPFS_P12_MCLK_BIT  2
`define PPFS_P12_SCLK_BIT  4
`endif

// ==== src/ppfs_pkg.sv ====
`include "ppfs_params.svh"
package ppfs_pkg;
   typedef struct packed {
      logic [`PPFS_P1_W-1:0]   p1_data;
      logic [`PPFS_P1_W-1:0]   p1_dir;
      logic [`PPFS_P1_W-1:0]   p1_pu;
      logic [`PPFS_P1_W-1:0]   p1_mode;
      logic [`PPFS_P2_W-1:0]   p2_data;
      logic [`PPFS_P2_W-1:0]   p2_dir;
      logic [`PPFS_P2_W-1:0]   p2_analog;
      logic [`PPFS_P3_W-1:0]   p3_data;
      logic [`PPFS_P3_W-1:0]   p3_dir;
      logic [`PPFS_P3_W-1:0]   p3_pu;
      logic [`PPFS_P3_W-1:0]   p3_mode;
      logic [`PPFS_P6_W-1:0]   p6_data;
      logic [`PPFS_P6_W-1:0]   p6_dir;
      logic [`PPFS_P6_W-1:0]   p6_mode;
      logic [`PPFS_P7_W-1:0]   p7_data;
      logic [`PPFS_P7_W-1:0]   p7_dir;
      logic [`PPFS_P7_W-1:0]   p7_pu;
      logic [`PPFS_P7_W-1:0]   p7_mode;
      logic [`PPFS_P12_W-1:0]  p12_data;
      logic [`PPFS_P12_W-1:0]  p12_dir;
      logic [`PPFS_P12_W-1:0]  p12_mode;
      logic                    p12_pu;
      logic [`PPFS_INTP_N-1:0] edge_rise;
      logic [`PPFS_INTP_N-1:0] edge_fall;
      logic [`PPFS_IRQ_W-1:0]  irq_status;
      logic [`PPFS_IRQ_W-1:0]  irq_mask;
      logic                    uart_sel;
      logic [`PPFS_DW-1:0]     rdata;
   } ppfs_state_t;

   parameter ppfs_state_t PPFS_STATE_RST = '{p2_analog: `PPFS_P2_ANALOG_RST, default: '0};

   typedef struct packed {
      logic prev;
   } ppfs_edge_state_t;
endpackage

// ==== src/ppfs_edge_detect.sv ====
`timescale 1ns/1ps
// one-bit edge detector with separate rising and falling enables
module ppfs_edge_detect (
   input  wire logic i_clock,
   input  wire logic i_rstn,
   input  wire logic i_level,
   input  wire logic i_rise_en,
   input  wire logic i_fall_en,
   output logic      o_event
);
   ppfs_pkg::ppfs_edge_state_t st;
   ppfs_pkg::ppfs_edge_state_t next_st;

   always_comb begin
      next_st      = st;
      next_st.prev = i_level;
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_event = (i_rise_en & i_level & ~st.prev) | (i_fall_en & ~i_level & st.prev);
endmodule // ppfs_edge_detect

// ==== src/ppfs_top.sv ====
// Function
// - per-bit choice of port or alternate function
// - per-bit direction from direction register
// - pull-up option on ports 1, 3, 7
// - port 12 pull-up on lowest pin only
// - port 2 analog input after reset
// - port 6 outputs open-drain, low only
// - external interrupts on rising, falling or both
// - port 1 carries serial, uart, timer, interrupt
// - port 3 carries four interrupts, timer pins
// - port 6 is i2c clock then data
// - port 7 pins are key interrupt inputs
// - port 12 interrupt, voltage sense, clock pins
// - active-low reset holds the device
`timescale 1ns/1ps
`include "ppfs_params.svh"
module ppfs_top (
   input  wire logic                    i_clock,
   input  wire logic                    i_rstn,
   input  wire logic [`PPFS_AW-1:0]     i_addr,
   input  wire logic [`PPFS_DW-1:0]     i_wdata,
   input  wire logic                    i_wr,
   input  wire logic                    i_rd,
   output logic      [`PPFS_DW-1:0]     o_rdata,
   output logic                         o_irq,
   // pins
   input  wire logic [`PPFS_P1_W-1:0]   i_p1_in,
   output logic      [`PPFS_P1_W-1:0]   o_p1_out,
   output logic      [`PPFS_P1_W-1:0]   o_p1_oe,
   output logic      [`PPFS_P1_W-1:0]   o_p1_pullup,
   input  wire logic [`PPFS_P2_W-1:0]   i_p2_in,
   output logic      [`PPFS_P2_W-1:0]   o_p2_out,
   output logic      [`PPFS_P2_W-1:0]   o_p2_oe,
   output logic      [`PPFS_P2_W-1:0]   o_p2_analog_en,
   input  wire logic [`PPFS_P3_W-1:0]   i_p3_in,
   output logic      [`PPFS_P3_W-1:0]   o_p3_out,
   output logic      [`PPFS_P3_W-1:0]   o_p3_oe,
   output logic      [`PPFS_P3_W-1:0]   o_p3_pullup,
   input  wire logic [`PPFS_P6_W-1:0]   i_p6_in,
   output logic      [`PPFS_P6_W-1:0]   o_p6_out,
   output logic      [`PPFS_P6_W-1:0]   o_p6_oe,
   input  wire logic [`PPFS_P7_W-1:0]   i_p7_in,
   output logic      [`PPFS_P7_W-1:0]   o_p7_out,
   output logic      [`PPFS_P7_W-1:0]   o_p7_oe,
   output logic      [`PPFS_P7_W-1:0]   o_p7_pullup,
   input  wire logic [`PPFS_P12_W-1:0]  i_p12_in,
   output logic      [`PPFS_P12_W-1:0]  o_p12_out,
   output logic      [`PPFS_P12_W-1:0]  o_p12_oe,
   output logic      [`PPFS_P12_W-1:0]  o_p12_pullup,
   // peripheral side
   input  wire logic                    i_sync_serial_data_out,
   input  wire logic                    i_sync_serial_clock_out,
   output logic                         o_sync_serial_data_in,
   output logic                         o_sync_serial_clock_in,
   input  wire logic                    i_uart_a_transmit,
   input  wire logic                    i_uart_b_transmit,
   output logic                         o_uart_a_receive,
   output logic                         o_uart_b_receive,
   input  wire logic                    i_timer8_a_out,
   input  wire logic                    i_timer8_b_out,
   input  wire logic                    i_timer_h_a_out,
   input  wire logic                    i_timer_h_b_out,
   output logic                         o_timer8_a_count_in,
   output logic                         o_timer8_b_count_in,
   input  wire logic                    i_i2c_clock_pull_low,
   input  wire logic                    i_i2c_data_pull_low,
   output logic                         o_i2c_clock_pin,
   output logic                         o_i2c_data_pin,
   output logic      [`PPFS_P2_W-1:0]   o_analog_channel,
   output logic                         o_ext_low_voltage_sense,
   output logic                         o_main_ext_clock_in,
   output logic                         o_sub_ext_clock_in,
   output logic      [`PPFS_INTP_N-1:0] o_ext_irq_event,
   output logic                         o_key_irq_event
);
   ppfs_pkg::ppfs_state_t       st;
   ppfs_pkg::ppfs_state_t       next_st;
   logic [`PPFS_INTP_N-1:0]     intp_level;
   logic [`PPFS_INTP_N-1:0]     intp_sel;
   logic [`PPFS_INTP_N-1:0]     intp_raw;
   logic [`PPFS_INTP_N-1:0]     ext_evt;
   logic [`PPFS_P7_W-1:0]       key_fall;
   logic                        key_evt;
   logic [`PPFS_IRQ_W-1:0]      irq_events;
   logic [`PPFS_P1_W-1:0]       p1_alt;
   logic [`PPFS_P3_W-1:0]       p3_alt;
   logic [`PPFS_P2_W-1:0]       p2_digital;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt sources
   // ext_irq_input_zero on port 12, intp1..4 on port 3, ext_irq_input_five on port 1
   assign intp_level = {i_p1_in[`PPFS_P1_TOHB_BIT], i_p3_in, i_p12_in[`PPFS_P12_INTP_BIT]};
   assign intp_sel   = {st.p1_mode[`PPFS_P1_TOHB_BIT], st.p3_mode, st.p12_mode[`PPFS_P12_INTP_BIT]};

   generate
      for (genvar k = 0; k < `PPFS_INTP_N; k++) begin : g_intp
         ppfs_edge_detect u_edge (
            .i_clock   (i_clock),
            .i_rstn    (i_rstn),
            .i_level   (intp_level[k]),
            .i_rise_en (st.edge_rise[k]),
            .i_fall_en (st.edge_fall[k]),
            .o_event   (intp_raw[k])
         );
      end
      // a key press pulls the pin low, so only the falling edge counts
      for (genvar k = 0; k < `PPFS_P7_W; k++) begin : g_key
         ppfs_edge_detect u_edge (
            .i_clock   (i_clock),
            .i_rstn    (i_rstn),
            .i_level   (i_p7_in[k]),
            .i_rise_en (1'b0),
            .i_fall_en (1'b1),
            .o_event   (key_fall[k])
         );
      end
   endgenerate

   // the detector runs in both modes so that entering alternate mode sees a fresh history
   assign ext_evt    = intp_raw & intp_sel;
   assign key_evt    = |(key_fall & st.p7_mode);
   assign irq_events = {key_evt, ext_evt};

   ////////////////////////////////////////////////////////////////////////////
   // register file and state
   always_comb begin
      next_st       = st;
      next_st.rdata = '0;
      if (i_wr) begin
         case (i_addr)
            `PPFS_P1_DATA    : next_st.p1_data  = i_wdata;
            `PPFS_P1_DIR     : next_st.p1_dir   = i_wdata;
            `PPFS_P1_PU      : next_st.p1_pu    = i_wdata;
            `PPFS_P1_MODE    : next_st.p1_mode  = i_wdata;
            `PPFS_P2_DATA    : next_st.p2_data  = i_wdata;
            `PPFS_P2_DIR     : next_st.p2_dir   = i_wdata;
            `PPFS_P2_ANALOG  : next_st.p2_analog = i_wdata;
            `PPFS_P3_DATA    : next_st.p3_data  = i_wdata[`PPFS_P3_W-1:0];
            `PPFS_P3_DIR     : next_st.p3_dir   = i_wdata[`PPFS_P3_W-1:0];
            `PPFS_P3_PU      : next_st.p3_pu    = i_wdata[`PPFS_P3_W-1:0];
            `PPFS_P3_MODE    : next_st.p3_mode  = i_wdata[`PPFS_P3_W-1:0];
            `PPFS_P6_DATA    : next_st.p6_data  = i_wdata[`PPFS_P6_W-1:0];
            `PPFS_P6_DIR     : next_st.p6_dir   = i_wdata[`PPFS_P6_W-1:0];
            `PPFS_P6_MODE    : next_st.p6_mode  = i_wdata[`PPFS_P6_W-1:0];
            `PPFS_P7_DATA    : next_st.p7_data  = i_wdata;
            `PPFS_P7_DIR     : next_st.p7_dir   = i_wdata;
            `PPFS_P7_PU      : next_st.p7_pu    = i_wdata;
            `PPFS_P7_MODE    : next_st.p7_mode  = i_wdata;
            `PPFS_P12_DATA   : next_st.p12_data = i_wdata[`PPFS_P12_W-1:0];
            `PPFS_P12_DIR    : next_st.p12_dir  = i_wdata[`PPFS_P12_W-1:0];
            `PPFS_P12_PU     : next_st.p12_pu   = i_wdata[0];
            `PPFS_P12_MODE   : next_st.p12_mode = i_wdata[`PPFS_P12_W-1:0];
            `PPFS_EDGE_RISE  : next_st.edge_rise = i_wdata[`PPFS_INTP_N-1:0];
            `PPFS_EDGE_FALL  : next_st.edge_fall = i_wdata[`PPFS_INTP_N-1:0];
            `PPFS_IRQ_STATUS : next_st.irq_status = st.irq_status & ~i_wdata[`PPFS_IRQ_W-1:0];
            `PPFS_IRQ_MASK   : next_st.irq_mask = i_wdata[`PPFS_IRQ_W-1:0];
            `PPFS_SERIAL_SEL : next_st.uart_sel = i_wdata[0];
            default          : next_st = next_st;
         endcase
      end
      // set after the clear so that an event in the clearing cycle survives
      next_st.irq_status = next_st.irq_status | irq_events;
      if (i_rd) begin
         case (i_addr)
            // data reads return the latch for outputs and the pin for inputs, zero for port 2 analog inputs; port 6 returns the pin for all bits
            `PPFS_P1_DATA    : next_st.rdata = (st.p1_dir & st.p1_data) | (~st.p1_dir & i_p1_in);
            `PPFS_P1_DIR     : next_st.rdata = st.p1_dir;
            `PPFS_P1_PU      : next_st.rdata = st.p1_pu;
            `PPFS_P1_MODE    : next_st.rdata = st.p1_mode;
            `PPFS_P2_DATA    : next_st.rdata = (st.p2_dir & st.p2_data) | (~st.p2_dir & p2_digital);
            `PPFS_P2_DIR     : next_st.rdata = st.p2_dir;
            `PPFS_P2_ANALOG  : next_st.rdata = st.p2_analog;
            `PPFS_P3_DATA    : next_st.rdata = {4'h0, (st.p3_dir & st.p3_data) | (~st.p3_dir & i_p3_in)};
            `PPFS_P3_DIR     : next_st.rdata = {4'h0, st.p3_dir};
            `PPFS_P3_PU      : next_st.rdata = {4'h0, st.p3_pu};
            `PPFS_P3_MODE    : next_st.rdata = {4'h0, st.p3_mode};
            `PPFS_P6_DATA    : next_st.rdata = {6'h00, i_p6_in};
            `PPFS_P6_DIR     : next_st.rdata = {6'h00, st.p6_dir};
            `PPFS_P6_MODE    : next_st.rdata = {6'h00, st.p6_mode};
            `PPFS_P7_DATA    : next_st.rdata = (st.p7_dir & st.p7_data) | (~st.p7_dir & i_p7_in);
            `PPFS_P7_DIR     : next_st.rdata = st.p7_dir;
            `PPFS_P7_PU      : next_st.rdata = st.p7_pu;
            `PPFS_P7_MODE    : next_st.rdata = st.p7_mode;
            `PPFS_P12_DATA   : next_st.rdata = {3'h0, (st.p12_dir & st.p12_data) | (~st.p12_dir & i_p12_in)};
            `PPFS_P12_DIR    : next_st.rdata = {3'h0, st.p12_dir};
            `PPFS_P12_PU     : next_st.rdata = {7'h00, st.p12_pu};
            `PPFS_P12_MODE   : next_st.rdata = {3'h0, st.p12_mode};
            `PPFS_EDGE_RISE  : next_st.rdata = {2'h0, st.edge_rise};
            `PPFS_EDGE_FALL  : next_st.rdata = {2'h0, st.edge_fall};
            `PPFS_IRQ_STATUS : next_st.rdata = {1'h0, st.irq_status};
            `PPFS_IRQ_MASK   : next_st.rdata = {1'h0, st.irq_mask};
            `PPFS_SERIAL_SEL : next_st.rdata = {7'h00, st.uart_sel};
            default          : next_st.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= ppfs_pkg::PPFS_STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata = st.rdata;
   assign o_irq   = |(st.irq_status & st.irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // pin drivers
   assign p1_alt = {i_timer8_a_out, i_timer_h_b_out, i_timer_h_a_out, 1'b0, i_uart_b_transmit,
                    i_sync_serial_data_out, 1'b0,
                    st.uart_sel ? i_uart_a_transmit : i_sync_serial_clock_out};
   assign p3_alt = {i_timer8_b_out, 3'h0};

   assign o_p1_out    = (st.p1_mode & p1_alt) | (~st.p1_mode & st.p1_data);
   assign o_p1_oe     = st.p1_dir;
   assign o_p1_pullup = st.p1_pu & ~st.p1_dir;

   // analog pins never drive and feed no digital logic
   assign p2_digital     = i_p2_in & ~st.p2_analog;
   assign o_p2_out       = st.p2_data;
   assign o_p2_oe        = st.p2_dir & ~st.p2_analog;
   assign o_p2_analog_en = st.p2_analog;
   assign o_analog_channel = i_p2_in & st.p2_analog;

   assign o_p3_out    = (st.p3_mode & p3_alt) | (~st.p3_mode & st.p3_data);
   assign o_p3_oe     = st.p3_dir;
   assign o_p3_pullup = st.p3_pu & ~st.p3_dir;

   // open drain: the pin only ever sinks, a one is released to the external pull-up
   assign o_p6_out = '0;
   assign o_p6_oe  = (~st.p6_mode & st.p6_dir & ~st.p6_data) |
                     (st.p6_mode & {i_i2c_data_pull_low, i_i2c_clock_pull_low});

   assign o_p7_out    = st.p7_data;
   assign o_p7_oe     = st.p7_dir;
   assign o_p7_pullup = st.p7_pu & ~st.p7_dir;

   // resonator and clock pins must not be driven while in alternate mode
   assign o_p12_out    = st.p12_data;
   assign o_p12_oe     = st.p12_dir & ~st.p12_mode;
   assign o_p12_pullup = {4'h0, st.p12_pu & ~st.p12_dir[0]};

   ////////////////////////////////////////////////////////////////////////////
   // peripheral inputs, gated by the alternate selection except the i2c pins
   assign o_sync_serial_clock_in  = st.p1_mode[`PPFS_P1_SCK_BIT] & i_p1_in[`PPFS_P1_SCK_BIT];
   assign o_sync_serial_data_in   = st.p1_mode[`PPFS_P1_SI_BIT] & ~st.uart_sel & i_p1_in[`PPFS_P1_SI_BIT];
   assign o_uart_a_receive        = st.p1_mode[`PPFS_P1_SI_BIT] & st.uart_sel & i_p1_in[`PPFS_P1_SI_BIT];
   assign o_uart_b_receive        = st.p1_mode[`PPFS_P1_RXB_BIT] & i_p1_in[`PPFS_P1_RXB_BIT];
   assign o_timer8_a_count_in     = st.p1_mode[`PPFS_P1_T8A_BIT] & i_p1_in[`PPFS_P1_T8A_BIT];
   assign o_timer8_b_count_in     = st.p3_mode[`PPFS_P3_T8B_BIT] & i_p3_in[`PPFS_P3_T8B_BIT];
   assign o_i2c_clock_pin         = i_p6_in[0];
   assign o_i2c_data_pin          = i_p6_in[1];
   assign o_ext_low_voltage_sense = st.p12_mode[`PPFS_P12_INTP_BIT] & i_p12_in[`PPFS_P12_INTP_BIT];
   assign o_main_ext_clock_in     = st.p12_mode[`PPFS_P12_MCLK_BIT] & i_p12_in[`PPFS_P12_MCLK_BIT];
   assign o_sub_ext_clock_in      = st.p12_mode[`PPFS_P12_SCLK_BIT] & i_p12_in[`PPFS_P12_SCLK_BIT];
   assign o_ext_irq_event         = ext_evt;
   assign o_key_irq_event         = key_evt;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic wr_seen;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_seen <= 1'b0;
      end else if (i_wr) begin
         wr_seen <= 1'b1;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);

   AST_PORT_MODE_LATCH: assert property (((o_p1_out ^ st.p1_data) & ~st.p1_mode) == '0)
      else $error("port-mode pin does not follow its latch");
   AST_DIR_WRITE: assert property (i_wr && i_addr == `PPFS_P1_DIR |=> o_p1_oe == $past(i_wdata))
      else $error("direction write not applied to enables");
   AST_PULLUP_INPUT: assert property ((o_p7_pullup & o_p7_oe) == '0 && (o_p1_pullup & ~st.p1_pu) == '0)
      else $error("pull-up on output or unselected pin");
   AST_P12_PULLUP: assert property (o_p12_pullup[`PPFS_P12_W-1:1] == '0)
      else $error("pull-up on upper port 12 pin");
   AST_P2_ANALOG: assert property (!wr_seen |-> o_p2_analog_en == `PPFS_P2_ANALOG_RST && o_p2_oe == '0)
      else $error("port 2 not analog after reset");
   AST_OPEN_DRAIN: assert property (o_p6_out == '0 and (i_wr && i_addr == `PPFS_P6_DATA && st.p6_mode == '0
                                   && st.p6_dir == 2'h3 ##1 st.p6_dir == 2'h3 |-> o_p6_oe == ~$past(i_wdata[1:0])))
      else $error("port 6 drives high or misses low");
   AST_EDGE_SET: assert property (|ext_evt |=> (st.irq_status & {1'b0, $past(ext_evt)}) == {1'b0, $past(ext_evt)})
      else $error("external interrupt edge not latched");
   AST_KEY_SET: assert property (key_evt |=> st.irq_status[`PPFS_KEY_BIT] ##1 st.irq_status[`PPFS_KEY_BIT]
                                 || $past(i_wr, 1) || i_wr)
      else $error("key interrupt not latched");
   AST_IRQ_OUT: assert property ($rose(o_irq) |-> $past(|irq_events) || $past(i_wr))
      else $error("interrupt rose without a cause");
   AST_RESET_IDLE: assert property (!wr_seen |-> o_p1_oe == '0 && o_p7_oe == '0 && o_p1_pullup == '0)
      else $error("pin driven before configuration");
   AST_I2C_MAP: assert property (st.p6_mode == 2'h3 |-> o_p6_oe == {i_i2c_data_pull_low, i_i2c_clock_pull_low})
      else $error("i2c pins swapped");
   AST_READ_IDLE: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data outside read slot");

   COV_EXT_EVENT: cover property (|ext_evt);
   COV_KEY_EVENT: cover property (key_evt);
   COV_IRQ: cover property ($rose(o_irq));
   COV_STATUS_READ: cover property (i_rd && i_addr == `PPFS_IRQ_STATUS ##1 o_rdata != '0);
endmodule // ppfs_top

// ==== dv/ppfs_pin_model.sv ====
`timescale 1ns/1ps
// resolves one port's wires from the device drive, the outside driver and the pull-ups
module ppfs_pin_model #(
   parameter int   W    = 8,
   parameter logic PULL = 1'b0
) (
   input  wire logic [W-1:0] i_oe,
   input  wire logic [W-1:0] i_out,
   input  wire logic [W-1:0] i_pullup,
   input  wire logic [W-1:0] i_ext_en,
   input  wire logic [W-1:0] i_ext_val,
   output logic      [W-1:0] o_pin
);
   // an undriven wire with no pull shows the inverse of the latch, so a stale value never passes
   always_comb begin
      for (int i = 0; i < W; i++) begin
         o_pin[i] = i_oe[i] ? i_out[i] : i_ext_en[i] ? i_ext_val[i] : (i_pullup[i] | PULL) ? 1'b1 : ~i_out[i];
      end
   end
endmodule // ppfs_pin_model

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "ppfs_params.svh"
module testbench;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [3:0] s; logic [7:0] e;} ppfs_row_t;
   logic       clk, rstn, wr, rd, irq, uar, mclk, sda, scl;
   logic [7:0] e2, v2, ach;
   logic [7:0] addr, wdata, rdata, p1i, p1o, p1e, p1u, p2i, p2o, p2e, p2a, p7i, p7o, p7e, p7u, e1, v1, e7, v7;
   logic [3:0] p3i, p3o, p3e, p3u, e3, v3;
   logic [1:0] p6i, p6o, p6e, e6, v6;
   logic [4:0] p12i, p12o, p12e, p12u, e12, v12;
   logic [9:0] pr;
   int         mismatches = 0;
   int         n_checks = 0;
   ppfs_row_t  rows [11] = '{'{`PPFS_P1_DIR, 8'hA5, 0, 8'hA5}, '{`PPFS_P1_PU, 8'hFF, 3, 8'h5A},
      '{`PPFS_P3_DIR, 8'h09, 1, 8'h09}, '{`PPFS_P3_PU, 8'h0F, 4, 8'h06}, '{`PPFS_P7_DIR, 8'hF0, 2, 8'hF0},
      '{`PPFS_P7_PU, 8'hFF, 5, 8'h0F}, '{`PPFS_P12_PU, 8'hFF, 6, 8'h01}, '{`PPFS_P12_DIR, 8'h1F, 9, 8'h1F},
      '{`PPFS_P2_ANALOG, 8'h0F, 8, 8'h0F}, '{`PPFS_P6_DIR, 8'h03, 7, 8'h03}, '{`PPFS_P6_DATA, 8'h02, 7, 8'h01}};
   ppfs_pin_model m1 (.i_oe(p1e), .i_out(p1o), .i_pullup(p1u), .i_ext_en(e1), .i_ext_val(v1), .o_pin(p1i));
   ppfs_pin_model m2 (.i_oe(p2e), .i_out(p2o), .i_pullup(8'h00), .i_ext_en(e2), .i_ext_val(v2), .o_pin(p2i));
   ppfs_pin_model #(.W(4)) m3 (.i_oe(p3e), .i_out(p3o), .i_pullup(p3u), .i_ext_en(e3), .i_ext_val(v3), .o_pin(p3i));
   // the i2c wires carry an outside pull-up
   ppfs_pin_model #(.W(2)) m6 (.i_oe(p6e), .i_out(p6o), .i_pullup(2'b11), .i_ext_en(e6), .i_ext_val(v6),
      .o_pin(p6i));
   ppfs_pin_model m7 (.i_oe(p7e), .i_out(p7o), .i_pullup(p7u), .i_ext_en(e7), .i_ext_val(v7), .o_pin(p7i));
   ppfs_pin_model #(.W(5)) m12 (.i_oe(p12e), .i_out(p12o), .i_pullup(p12u), .i_ext_en(e12), .i_ext_val(v12),
      .o_pin(p12i));
   ppfs_top dut (.i_clock(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .o_irq(irq), .i_p1_in(p1i), .o_p1_out(p1o), .o_p1_oe(p1e), .o_p1_pullup(p1u),
      .i_p2_in(p2i), .o_p2_out(p2o), .o_p2_oe(p2e), .o_p2_analog_en(p2a), .i_p3_in(p3i), .o_p3_out(p3o),
      .o_p3_oe(p3e), .o_p3_pullup(p3u), .i_p6_in(p6i), .o_p6_out(p6o), .o_p6_oe(p6e), .i_p7_in(p7i),
      .o_p7_out(p7o), .o_p7_oe(p7e), .o_p7_pullup(p7u), .i_p12_in(p12i), .o_p12_out(p12o), .o_p12_oe(p12e),
      .o_p12_pullup(p12u), .i_sync_serial_data_out(pr[0]), .i_sync_serial_clock_out(pr[1]),
      .o_sync_serial_data_in(), .o_sync_serial_clock_in(), .i_uart_a_transmit(pr[2]), .i_uart_b_transmit(pr[3]),
      .o_uart_a_receive(uar), .o_uart_b_receive(), .i_timer8_a_out(pr[4]), .i_timer8_b_out(pr[5]),
      .i_timer_h_a_out(pr[6]), .i_timer_h_b_out(pr[7]), .o_timer8_a_count_in(), .o_timer8_b_count_in(),
      .i_i2c_clock_pull_low(pr[8]), .i_i2c_data_pull_low(pr[9]), .o_i2c_clock_pin(scl), .o_i2c_data_pin(sda),
      .o_analog_channel(ach), .o_ext_low_voltage_sense(), .o_main_ext_clock_in(mclk), .o_sub_ext_clock_in(),
      .o_ext_irq_event(), .o_key_irq_event());
   //////////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] obs(input logic [3:0] s);
      case (s)
         0: obs = p1e;  1: obs = 8'(p3e);  2: obs = p7e;  3: obs = p1u;  4: obs = 8'(p3u);
         5: obs = p7u;  6: obs = 8'(p12u); 7: obs = 8'(p6e); 8: obs = p2a; default: obs = 8'(p12e);
      endcase
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      n_checks++;
      if (g !== x) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, g, x);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_t(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_t(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, x);
   endtask
   task automatic reset_chk();
      chk(8'(|{p1e, p2e, p3e, p6e, p7e, p12e, p1u, p3u, p7u, p12u, irq}), 8'h00);
      chk(p2a, 8'hFF);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #100000;
      mismatches++;
      complete_run();
   end
   initial begin
      rstn = 0; wr = 0; rd = 0; addr = '0; wdata = '0; pr = '0;
      e1 = '0; v1 = '0; e3 = '0; v3 = '0; e7 = '0; v7 = '0; e12 = '0; v12 = '0;
      e2 = '0; v2 = '0; e6 = '0; v6 = '0;
      cyc(12);
      reset_chk();
      rstn <= 1'b1;
      cyc(1);
      reset_chk();
      $display("reset test done");
      foreach (rows[i]) begin
         wr_t(rows[i].a, rows[i].d);
         chk(obs(rows[i].s), rows[i].e);
      end
      chk(8'(p6o), 8'h00);
      // analog pins pass to the converter and read back as zero
      e2 <= 8'hFF; v2 <= 8'h3C;
      cyc(1);
      chk(ach, 8'h0C);
      rd_t(`PPFS_P2_DATA, 8'h30);
      $display("row test done");
      // timer output follows the peripheral only in alternate mode
      wr_t(`PPFS_P1_MODE, 8'h88);
      for (int b = 0; b < 2; b++) begin
         pr[4] <= b[0];
         pr[3] <= b[0];
         cyc(1);
         chk(8'(p1o[7]), 8'(b));
         chk(8'(p1o[3]), 8'(b));
      end
      wr_t(`PPFS_P1_MODE, 8'h00);
      chk(8'(p1o[7]), 8'h00);
      wr_t(`PPFS_SERIAL_SEL, 8'h01);
      wr_t(`PPFS_P1_MODE, 8'h02);
      e1 <= 8'h02; v1 <= 8'h02;
      cyc(1);
      chk(8'(uar), 8'h01);
      $display("port 1 test done");
      wr_t(`PPFS_P3_DIR, 8'h00);
      wr_t(`PPFS_P3_MODE, 8'h0F);
      wr_t(`PPFS_EDGE_RISE, 8'h02);
      wr_t(`PPFS_IRQ_MASK, 8'h7F);
      e3 <= 4'hF; v3 <= 4'h0;
      cyc(2);
      v3 <= 4'h1;
      cyc(3);
      chk(8'(irq), 8'h01);
      rd_t(`PPFS_IRQ_STATUS, 8'h02);
      wr_t(`PPFS_IRQ_STATUS, 8'h02);
      chk(8'(irq), 8'h00);
      v3 <= 4'h0;
      cyc(3);
      rd_t(`PPFS_IRQ_STATUS, 8'h00);
      wr_t(`PPFS_EDGE_RISE, 8'h00);
      wr_t(`PPFS_EDGE_FALL, 8'h02);
      v3 <= 4'h1;
      cyc(3);
      rd_t(`PPFS_IRQ_STATUS, 8'h00);
      v3 <= 4'h0;
      cyc(3);
      rd_t(`PPFS_IRQ_STATUS, 8'h02);
      wr_t(`PPFS_IRQ_MASK, 8'h00);
      chk(8'(irq), 8'h00);
      $display("edge test done");
      wr_t(`PPFS_P7_MODE, 8'hFF);
      e7 <= 8'hFF; v7 <= 8'hFF;
      cyc(3);
      wr_t(`PPFS_IRQ_STATUS, 8'h7F);
      v7 <= 8'hFE;
      cyc(3);
      rd_t(`PPFS_IRQ_STATUS, 8'h40);
      wr_t(`PPFS_P12_MODE, 8'h04);
      e12 <= 5'h04; v12 <= 5'h04;
      cyc(1);
      chk(8'(p12e), 8'h1B);
      chk(8'(mclk), 8'h01);
      wr_t(`PPFS_P6_MODE, 8'h03);
      pr[9] <= 1'b1;
      cyc(1);
      chk(8'(p6e), 8'h02);
      chk(8'(sda), 8'h00);
      pr[9] <= 1'b0;
      cyc(1);
      chk(8'(sda), 8'h01);
      e6 <= 2'b01; v6 <= 2'b00;
      cyc(1);
      chk(8'(scl), 8'h00);
      rd_t(8'h1F, 8'h00);
      $display("alternate test done");
      @(posedge clk);
      rstn <= 1'b0;
      cyc(2);
      reset_chk();
      rstn <= 1'b1;
      cyc(1);
      reset_chk();
      $display("second reset test done");
      complete_run();
   end
endmodule // testbench
